// ### hw/csse_defs.vh
`ifndef CSSE_DEFS_VH
`define CSSE_DEFS_VH

// Clock rate and frame timing
`define CSSE_CLK_HZ         20000000
`define CSSE_START_MS       150
`define CSSE_CELL_MS        150
`define CSSE_GAP_MS         5000
`define CSSE_MS_CYCLES      (`CSSE_CLK_HZ / 1000)
`define CSSE_START_CYC      (`CSSE_START_MS * `CSSE_MS_CYCLES)
`define CSSE_HALF_CYC       ((`CSSE_CELL_MS * `CSSE_MS_CYCLES) / 2)
`define CSSE_GAP_CYC        (`CSSE_GAP_MS * `CSSE_MS_CYCLES)

// Chain size and bit meaning
`define CSSE_MAX_SENSORS    16
`define CSSE_BIT_CLEAR      1'b0
`define CSSE_BIT_BREAK      1'b1

`endif

// ### hw/csse_safety_switch.v
`timescale 1ns/100ps
// Automatic-mode switching of both safety outputs with hysteresis
module csse_safety_switch (
    // Clock and reset
    input  wire mclk_i,
    input  wire rst_i,
    // Distance state and chain
    input  wire beyond_release_i,
    input  wire within_operate_i,
    input  wire upstream_ok_i,
    // Outputs
    output reg  safety_output_a_o,
    output reg  safety_output_b_o,
    output reg  local_clear_o
);
    reg clear_q;

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            clear_q <= 1'b0;
        end else if (beyond_release_i) begin
            clear_q <= 1'b0;                       // [RQ8]
        end else if (within_operate_i) begin
            clear_q <= 1'b1;                       // [RQ9]
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            safety_output_a_o <= 1'b0;
            safety_output_b_o <= 1'b0;
            local_clear_o     <= 1'b0;
        end else begin
            // Upstream loss forces both outputs off
            safety_output_a_o <= clear_q & upstream_ok_i;   // [RQ11]
            safety_output_b_o <= clear_q & upstream_ok_i;   // [RQ11]
            local_clear_o     <= clear_q;
        end
    end
endmodule

// ### hw/csse_status_encoder.v
`timescale 1ns/100ps
`include "csse_defs.vh"
// Notes on behaviour
// [RQ1] Status line idles high and stays high at least 5000 ms between characters.
// [RQ2] Each character opens with a 150 ms low start pulse.
// [RQ3] Zero bit: 150 ms cell, rising edge at its centre.
// [RQ4] One bit: 150 ms cell, falling edge at its centre.
// [RQ5] Character reports the whole series chain, not only this sensor.
// [RQ6] Sensor with actuator inside operate distance reports CLEAR.
// [RQ7] Sensor with actuator at release distance reports BREAK.
// [RQ8] Automatic mode: both safety outputs off beyond release distance.
// [RQ9] Automatic mode: both outputs back on below operate distance, no restart.
// [RQ10] Chain holds up to 16 sensors, each forwarding status downstream.
// [RQ11] Any deactivated upstream sensor deactivates this sensor's outputs.
// [RQ12] One bit per sensor, first to last; CLEAR=0, BREAK=1.
module csse_status_encoder #(
    parameter MAX_SENSORS = `CSSE_MAX_SENSORS,
    parameter START_CYC   = `CSSE_START_CYC,
    parameter HALF_CYC    = `CSSE_HALF_CYC,
    parameter GAP_CYC     = `CSSE_GAP_CYC
) (
    // Clock and reset
    input  wire                   mclk_i,
    input  wire                   rst_i,
    // Local distance state
    input  wire                   beyond_release_i,
    input  wire                   within_operate_i,
    // Chain from upstream sensors, index 0 is the first sensor
    input  wire [MAX_SENSORS-1:0] upstream_break_i,
    input  wire [4:0]             upstream_count_i,
    input  wire                   upstream_ok_i,
    // Safety outputs
    output wire                   safety_output_a_o,
    output wire                   safety_output_b_o,
    // Diagnostic line
    output reg                    status_line_o,
    output reg                    frame_busy_o
);
    localparam ST_GAP   = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_FIRST = 2'h2;
    localparam ST_SECND = 2'h3;

    reg  [1:0]             state_q;
    reg  [31:0]            cnt_q;
    reg  [4:0]             bit_q;
    reg  [4:0]             nbits_q;
    reg  [MAX_SENSORS-1:0] shadow_q;
    wire                   local_clear;
    wire [4:0]             cnt_lim;
    reg  [MAX_SENSORS-1:0] frame_d;
    reg  [4:0]             nbits_d;
    reg  [1:0]             state_d;
    reg  [31:0]            cnt_d;
    reg  [4:0]             bit_d;
    reg                    line_d;
    reg                    busy_d;
    reg                    load_frame;

    // Chain length clipped so the local bit always fits
    function [4:0] clip_count;
        input [4:0] count;
        begin
            if (count > MAX_SENSORS - 1) begin
                clip_count = MAX_SENSORS[4:0] - 5'h01;
            end else begin
                clip_count = count;
            end
        end
    endfunction

    // First half of a cell carries the bit value itself
    function cell_first_half;
        input bit_val;
        begin
            cell_first_half = bit_val;
        end
    endfunction

    // Second half inverts, so the centre edge encodes the bit
    function cell_second_half;
        input bit_val;
        begin
            cell_second_half = ~bit_val;
        end
    endfunction

    // Shared expiry test; the counter restarts at zero on every phase change
    function timer_done;
        input [31:0] count;
        input [31:0] limit;
        begin
            timer_done = (count >= limit - 32'h0000_0001);
        end
    endfunction

    // True on the final cell of the captured frame
    function last_cell;
        input [4:0] index;
        input [4:0] total;
        begin
            last_cell = ((index + 5'h01) >= total);
        end
    endfunction

    csse_safety_switch u_switch (
        .mclk_i            (mclk_i),
        .rst_i             (rst_i),
        .beyond_release_i  (beyond_release_i),
        .within_operate_i  (within_operate_i),
        .upstream_ok_i     (upstream_ok_i),
        .safety_output_a_o (safety_output_a_o),
        .safety_output_b_o (safety_output_b_o),
        .local_clear_o     (local_clear)
    );

    // Longer chains lose their tail rather than the local bit
    assign cnt_lim = clip_count(upstream_count_i);                   // [RQ10]

    // Upstream bits then the local bit appended after them
    always @* begin
        frame_d = upstream_break_i;                                  // [RQ5]
        frame_d[cnt_lim[3:0]] = local_clear ? `CSSE_BIT_CLEAR
                                            : `CSSE_BIT_BREAK;       // [RQ6] [RQ7] [RQ12]
        nbits_d = cnt_lim + 5'h01;
    end

    // Next-state logic; chain inputs are only sampled when the gap ends
    always @* begin
        state_d    = state_q;
        cnt_d      = cnt_q + 32'h0000_0001;
        bit_d      = bit_q;
        line_d     = status_line_o;
        busy_d     = frame_busy_o;
        load_frame = 1'b0;
        case (state_q)
            ST_GAP: begin
                line_d = 1'b1;                                       // [RQ1]
                busy_d = 1'b0;
                if (timer_done(cnt_q, GAP_CYC)) begin                // [RQ1]
                    cnt_d      = 32'h0000_0000;
                    bit_d      = 5'h00;
                    line_d     = 1'b0;                               // [RQ2]
                    busy_d     = 1'b1;
                    load_frame = 1'b1;
                    state_d    = ST_START;
                end
            end
            ST_START: begin
                if (timer_done(cnt_q, START_CYC)) begin              // [RQ2]
                    cnt_d   = 32'h0000_0000;
                    line_d  = cell_first_half(shadow_q[0]);          // [RQ3] [RQ4]
                    state_d = ST_FIRST;
                end
            end
            ST_FIRST: begin
                if (timer_done(cnt_q, HALF_CYC)) begin
                    cnt_d   = 32'h0000_0000;
                    line_d  = cell_second_half(shadow_q[bit_q[3:0]]); // [RQ3] [RQ4]
                    state_d = ST_SECND;
                end
            end
            ST_SECND: begin
                if (timer_done(cnt_q, HALF_CYC)) begin
                    cnt_d = 32'h0000_0000;
                    if (last_cell(bit_q, nbits_q)) begin
                        // Line returns high at once, so the gap starts here
                        line_d  = 1'b1;                              // [RQ1]
                        busy_d  = 1'b0;
                        state_d = ST_GAP;
                    end else begin
                        bit_d   = bit_q + 5'h01;                     // [RQ12]
                        line_d  = cell_first_half(shadow_q[bit_q[3:0] + 4'h1]);
                        state_d = ST_FIRST;
                    end
                end
            end
            default: begin
                cnt_d   = 32'h0000_0000;
                line_d  = 1'b1;
                busy_d  = 1'b0;
                state_d = ST_GAP;
            end
        endcase
    end

    // Frame is frozen for its whole length; late chain changes wait
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state_q       <= ST_GAP;
            cnt_q         <= 32'h0000_0000;
            bit_q         <= 5'h00;
            nbits_q       <= 5'h01;
            shadow_q      <= {MAX_SENSORS{1'b0}};
            status_line_o <= 1'b1;
            frame_busy_o  <= 1'b0;
        end else begin
            state_q       <= state_d;
            cnt_q         <= cnt_d;
            bit_q         <= bit_d;
            status_line_o <= line_d;
            frame_busy_o  <= busy_d;
            if (load_frame) begin
                shadow_q <= frame_d;
                nbits_q  <= nbits_d;
            end
        end
    end
endmodule

// ### verif/csse_checker.sv
`timescale 1ns/100ps
module csse_checker #(parameter GAP_CYC = 50) (
    // Design ports
    input wire mclk_i,
    input wire rst_i,
    input wire beyond_release_i,
    input wire within_operate_i,
    input wire upstream_ok_i,
    input wire safety_output_a_o,
    input wire safety_output_b_o,
    input wire status_line_o,
    input wire frame_busy_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    int gap_q;
    always @(posedge mclk_i or posedge rst_i)
        if (rst_i) gap_q <= 0;
        else gap_q <= frame_busy_o ? 0 : gap_q + 1;
    a_idle_high: assert property (!frame_busy_o |-> status_line_o)
        else $error("idle low");
    a_gap_min: assert property ($rose(frame_busy_o) |-> gap_q >= GAP_CYC - 1)
        else $error("gap short");
    a_start_low: assert property ($rose(frame_busy_o) |-> !status_line_o[*8] ##12 !status_line_o)
        else $error("start short");
    a_frame_len: assert property ($rose(frame_busy_o) |-> ##[40:340] !frame_busy_o)
        else $error("frame length");
    a_outputs_pair: assert property (safety_output_a_o == safety_output_b_o)
        else $error("outputs differ");
    a_off_beyond: assert property (beyond_release_i |-> ##2 !safety_output_a_o)
        else $error("not off");
    a_on_operate: assert property (
        (within_operate_i && !beyond_release_i && upstream_ok_i)[*3] |=> safety_output_a_o)
        else $error("not on");
    a_upstream_off: assert property (!upstream_ok_i |=> !safety_output_a_o)
        else $error("upstream off ignored");
    c_frame: cover property ($rose(frame_busy_o));
    c_off: cover property ($fell(safety_output_a_o));
    c_on: cover property ($rose(safety_output_a_o));
endmodule
bind csse_status_encoder csse_checker #(.GAP_CYC(GAP_CYC)) u_chk (.*);

// ### verif/csse_monitor.sv
`timescale 1ns/100ps
module csse_monitor #(parameter START_CYC = 20, HALF_CYC = 10) (
    input  wire        mclk_i,
    input  wire        line_i,
    output reg  [16:0] word_o,
    output reg  [4:0]  nbits_o,
    output reg         bad_o,
    output reg         done_o
);
    reg a;
    initial begin
        {word_o, nbits_o, bad_o, done_o} = 0;
        forever begin
            @(negedge line_i);
            {word_o, nbits_o} = 0;
            repeat (START_CYC + HALF_CYC / 2) @(posedge mclk_i);
            // Mid-half samples; no swap marks the end
            forever begin
                a = line_i;
                repeat (HALF_CYC) @(posedge mclk_i);
                if (a === line_i) break;
                word_o[nbits_o] = a;
                nbits_o = nbits_o + 1;
                repeat (HALF_CYC) @(posedge mclk_i);
            end
            bad_o = !a;
            done_o = 1;
            @(posedge mclk_i);
            done_o = 0;
        end
    end
endmodule

// ### verif/chain_status_serial_encoder_tb_top.sv
`timescale 1ns/100ps
module chain_status_serial_encoder_tb_top;
    reg         mclk_i = 0, rst_i = 1, st = 1;
    reg         beyond_release_i = 1, within_operate_i = 0, upstream_ok_i = 1;
    reg  [15:0] upstream_break_i = 16'h0000;
    reg  [4:0]  upstream_count_i = 5'h00;
    wire        safety_output_a_o, safety_output_b_o, status_line_o, frame_busy_o, bad, done;
    wire [16:0] word;
    wire [4:0]  nbits;
    reg  [31:0] r = 32'h0000_ff7f;
    reg  [21:0] q[$];
    integer     n_fail = 0, tests_run = 0, cyc = 0, i;
    always #25 mclk_i = ~mclk_i;
    csse_status_encoder #(.START_CYC(20), .HALF_CYC(10), .GAP_CYC(50)) dut (.*);
    csse_monitor mon (.mclk_i(mclk_i), .line_i(status_line_o), .word_o(word),
        .nbits_o(nbits), .bad_o(bad), .done_o(done));
    task report_and_stop;
        begin
            $display("checks %0d mismatches %0d", tests_run, n_fail);
            if (n_fail == 0 && tests_run > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    function [31:0] lfsr_next;
        input [31:0] s;
        begin
            lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        end
    endfunction
    task push_expect;
        reg [4:0]  c;
        reg [16:0] w;
        begin
            c = upstream_count_i > 15 ? 5'h0f : upstream_count_i;
            w = upstream_break_i & ((17'h0_0001 << c) - 1);
            w[c] = st;
            q.push_back({c + 5'h01, w});
        end
    endtask
    initial begin
        push_expect;
        repeat (6) @(posedge mclk_i);
        #1 rst_i = 0;
        // New chain lands mid-frame, so it must wait for the next one
        for (i = 0; i < 10; i = i + 1) begin
            @(posedge frame_busy_o) #1;
            tests_run = tests_run + 1;
            if ({safety_output_a_o, safety_output_b_o} !== {2{~st & upstream_ok_i}}) begin
                n_fail = n_fail + 1;
                $display("mismatch safety_outputs expected %b seen %b",
                    {2{~st & upstream_ok_i}}, {safety_output_a_o, safety_output_b_o});
            end
            r = lfsr_next(r);
            {upstream_break_i, upstream_count_i, upstream_ok_i} = r[21:0];
            {beyond_release_i, within_operate_i} = r[23:22];
            st = beyond_release_i ? 1'b1 : within_operate_i ? 1'b0 : st;
            push_expect;
        end
        @(posedge done);
        @(posedge mclk_i);
        report_and_stop;
    end
    always @(posedge done) begin
        tests_run = tests_run + 1;
        if (q.size() == 0 || {nbits, word} !== q[0] || bad !== 1'b0) begin
            n_fail = n_fail + 1;
            $display("mismatch status_frame expected %h seen %h", q[0], {nbits, word});
        end
        if (q.size() != 0) q.pop_front();
    end
    always @(posedge mclk_i) begin
        cyc = cyc + 1;
        if (cyc == 6000) begin
            n_fail = n_fail + 1;
            report_and_stop;
        end
    end
endmodule
